// ### rtl/cst_pkg.sv
/*
  Constants and carrier types of the card status record block.
  Assumes a 50 MHz clock, a synchronous active-high reset and byte addressing.
*/
package cst_pkg;
  // ----------------------------------------------------------------
  // Record width, field positions (lowest bit of each field) and maker area width.
  // ----------------------------------------------------------------
  localparam int REC_W = 512;
  localparam int POS_WIDTH = 510;
  localparam int POS_SECURE = 509;
  localparam int POS_CATEGORY = 480;
  localparam int POS_GUARDED = 448;
  localparam int POS_SPEED = 440;
  localparam int POS_MOVE = 432;
  localparam int POS_AU = 428;
  localparam int POS_ESIZE = 408;
  localparam int POS_ETMO = 402;
  localparam int POS_EOFF = 400;
  localparam int MAKER_W = 312;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_REC_FIRST = 8'h00;
  localparam logic [7:0] OFS_REC_LAST = 8'h3c;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_GUARDED = 8'h44;
  localparam logic [7:0] OFS_PERF = 8'h48;
  localparam logic [7:0] OFS_ERASE = 8'h4c;
  localparam logic [7:0] OFS_TXSTAT = 8'h50;

  // ----------------------------------------------------------------
  // Codes and reset values.
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_ONE = 2'h0;
  localparam logic [1:0] WIDTH_FOUR = 2'h2;
  localparam logic [15:0] CATEGORY_MEMORY = 16'h0000;
  localparam logic [7:0] SPEED_MAX = 8'h03;
  localparam logic [3:0] AU_MAX = 4'h9;
  localparam logic [3:0] AU_LIMIT_BASE = 4'h6;
  localparam logic [31:0] RST_GUARDED = 32'h02000000;
  localparam logic [7:0] RST_SPEED = 8'h02;
  localparam logic [7:0] RST_MOVE = 8'h02;
  localparam logic [3:0] RST_AU = 4'h9;
  localparam logic [1:0] RST_CAP = 2'h3;
  localparam logic [15:0] RST_ESIZE = 16'h0200;
  localparam logic [5:0] RST_ETMO = 6'h2a;
  localparam logic [1:0] RST_EOFF = 2'h2;
  localparam logic [8:0] TX_LAST = 9'h1ff;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cst_bus_s;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0] width;
    logic secure;
    logic [31:0] guarded;
    logic [7:0] speed;
    logic [7:0] move;
    logic [3:0] au;
    logic [1:0] cap;
    logic [15:0] esize;
    logic [5:0] etmo;
    logic [1:0] eoff;
    logic [REC_W-1:0] shift;
    logic [8:0] cnt;
    logic busy;
    logic [31:0] rdata;
  } cst_state_s;
endpackage

// ### rtl/cst_status_record.sv
/*
  Card status record: a 512-bit read-only record built from the card's live
  state, readable word by word over the register port and sent out serially.
  Assumes the command logic drives the port on the same clock, one strobe at
  a time, and pulses tx_start to request a serial copy of the record.
*/
// Local design decisions: the address map and the address-and-strobe port.
// Overview of operation
// - Top two bits show last chosen bus width, 00 one line, 10 four.
// - Bit 509 is one while secured mode is active, else zero.
// - Bits 495..480 carry the card category, zero for an ordinary card.
// - Bits 479..448 carry the guarded region size, thirty-two bits.
// - Bits 447..440 carry the speed grade code, 00h to 03h legal.
// - Bits 439..432 carry move performance in 1 MB/s steps.
// - Bits 431..428 carry the allocation unit code, 0h..9h legal.
// - The reported allocation unit never exceeds the capacity limit.
// - Bits 423..408 carry the erase unit count, zero means unsupported.
// - Bits 407..402 carry erase time limit in seconds, zero unsupported.
// - Bits 401..400 carry the fixed erase margin of 0 to 3 seconds.
// - No driver stage register, drive control or write protect exists.
`timescale 1ns/1ps
module cst_status_record (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Serial record output.
  input wire logic tx_start,
  output logic tx_valid,
  output logic tx_bit
);
  // ----------------------------------------------------------------
  // Record assembly.
  // ----------------------------------------------------------------
  cst_pkg::cst_state_s r, n;
  cst_pkg::cst_bus_s bus;
  logic [cst_pkg::REC_W-1:0] rec;
  logic [3:0] au_lim;
  logic [3:0] au_rep;

  // Bundle the port into one request.
  assign bus = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  // Clamp the allocation unit to what the capacity allows.
  assign au_lim = cst_pkg::AU_LIMIT_BASE + {2'h0, r.cap};
  assign au_rep = (r.au > au_lim) ? au_lim : r.au;

  // Build the record; gaps and the maker area read zero.
  always_comb begin
    rec = '0;
    rec[cst_pkg::POS_WIDTH +: 2] = r.width;
    rec[cst_pkg::POS_SECURE] = r.secure;
    rec[cst_pkg::POS_CATEGORY +: 16] = cst_pkg::CATEGORY_MEMORY;
    rec[cst_pkg::POS_GUARDED +: 32] = r.guarded;
    rec[cst_pkg::POS_SPEED +: 8] = r.speed;
    rec[cst_pkg::POS_MOVE +: 8] = r.move;
    rec[cst_pkg::POS_AU +: 4] = au_rep;
    rec[cst_pkg::POS_ESIZE +: 16] = r.esize;
    rec[cst_pkg::POS_ETMO +: 6] = r.etmo;
    rec[cst_pkg::POS_EOFF +: 2] = r.eoff;
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  // Register writes, reads and the serial shifter.
  always_comb begin
    int idx;
    idx = 0;
    n = r;
    n.rdata = '0;
    // Only the mapped registers below exist; no drive or protect control.
    if (bus.wr) begin
      unique case (bus.addr)
        cst_pkg::OFS_CTRL: begin
          // Reserved width codes are ignored so the field stays legal.
          if (bus.wdata[1:0] == cst_pkg::WIDTH_ONE ||
              bus.wdata[1:0] == cst_pkg::WIDTH_FOUR) begin
            n.width = bus.wdata[1:0];
          end
          n.secure = bus.wdata[2];
        end
        cst_pkg::OFS_GUARDED: begin
          n.guarded = bus.wdata;
        end
        cst_pkg::OFS_PERF: begin
          if (bus.wdata[7:0] <= cst_pkg::SPEED_MAX) begin
            n.speed = bus.wdata[7:0];
          end
          n.move = bus.wdata[15:8];
          if (bus.wdata[19:16] <= cst_pkg::AU_MAX) begin
            n.au = bus.wdata[19:16];
          end
          n.cap = bus.wdata[21:20];
        end
        cst_pkg::OFS_ERASE: begin
          n.esize = bus.wdata[15:0];
          n.etmo = bus.wdata[21:16];
          n.eoff = bus.wdata[25:24];
        end
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      if (bus.addr <= cst_pkg::OFS_REC_LAST && bus.addr[1:0] == 2'h0) begin
        idx = int'(bus.addr[5:2]);
        n.rdata = rec[cst_pkg::REC_W - 1 - 32 * idx -: 32];
      end else begin
        unique case (bus.addr)
          cst_pkg::OFS_CTRL: n.rdata = {29'h0, r.secure, r.width};
          cst_pkg::OFS_GUARDED: n.rdata = r.guarded;
          cst_pkg::OFS_PERF: n.rdata = {10'h0, r.cap, r.au, r.move, r.speed};
          cst_pkg::OFS_ERASE: n.rdata = {6'h0, r.eoff, 2'h0, r.etmo, r.esize};
          cst_pkg::OFS_TXSTAT: n.rdata = {22'h0, r.busy, r.cnt};
          default: n.rdata = '0;
        endcase
      end
    end
    // Serial copy: snapshot, then shift left so bit 511 leaves first.
    if (r.busy) begin
      n.shift = {r.shift[cst_pkg::REC_W-2:0], 1'b0};
      n.cnt = r.cnt + 9'h1;
      if (r.cnt == cst_pkg::TX_LAST) begin
        n.busy = 1'b0;
      end
    end else if (tx_start) begin
      n.shift = rec;
      n.cnt = '0;
      n.busy = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // Reset loads the shipped field values.
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.width <= cst_pkg::WIDTH_ONE;
      r.guarded <= cst_pkg::RST_GUARDED;
      r.speed <= cst_pkg::RST_SPEED;
      r.move <= cst_pkg::RST_MOVE;
      r.au <= cst_pkg::RST_AU;
      r.cap <= cst_pkg::RST_CAP;
      r.esize <= cst_pkg::RST_ESIZE;
      r.etmo <= cst_pkg::RST_ETMO;
      r.eoff <= cst_pkg::RST_EOFF;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata = r.rdata;
  assign tx_valid = r.busy;
  assign tx_bit = r.shift[cst_pkg::REC_W-1];

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // A start on an idle shifter.
  sequence s_tx_begin;
    tx_start && !r.busy;
  endsequence

  // The first bit out is the top record bit.
  sequence s_tx_first;
    tx_valid && tx_bit == $past(rec[cst_pkg::REC_W-1]);
  endsequence

  // A write to the control register.
  sequence s_ctrl_wr;
    wr_en && addr == cst_pkg::OFS_CTRL;
  endsequence

  // A write to the guarded size register.
  sequence s_guard_wr;
    wr_en && addr == cst_pkg::OFS_GUARDED;
  endsequence

  // A write to the performance register.
  sequence s_perf_wr;
    wr_en && addr == cst_pkg::OFS_PERF;
  endsequence

  // A write to the erase register.
  sequence s_erase_wr;
    wr_en && addr == cst_pkg::OFS_ERASE;
  endsequence

  a_width_four_taken: assert property (
    wr_en && addr == cst_pkg::OFS_CTRL && wdata[1:0] == cst_pkg::WIDTH_FOUR
    |=> rec[511:510] == cst_pkg::WIDTH_FOUR)
    else $error("Four-line width not reported after select.");

  a_width_reserved: assert property (
    wr_en && addr == cst_pkg::OFS_CTRL && wdata[0]
    |=> rec[511:510] == $past(rec[511:510]))
    else $error("Reserved width code changed the width field.");

  a_secure_bit: assert property (
    wr_en && addr == cst_pkg::OFS_CTRL |=> rec[509] == $past(wdata[2]))
    else $error("Secure flag does not follow the control write.");

  a_gaps_zero: assert property (
    rec[508:496] == '0 && rec[427:424] == '0 && rec[399:0] == '0)
    else $error("Reserved record bits are not zero.");

  a_category_zero: assert property (
    rec[495:480] == 16'h0000)
    else $error("Card category is not the ordinary code.");

  a_speed_legal: assert property (
    rec[447:440] <= cst_pkg::SPEED_MAX)
    else $error("Speed grade holds a reserved code.");

  a_au_limit: assert property (
    rec[431:428] <= au_lim && rec[431:428] <= cst_pkg::AU_MAX)
    else $error("Allocation unit exceeds the capacity limit.");

  a_tx_msb_first: assert property (
    s_tx_begin |=> s_tx_first)
    else $error("Serial copy did not start with bit 511.");

  a_tx_second_bit: assert property (
    s_tx_begin |=> ##1 tx_valid && tx_bit == $past(rec[cst_pkg::REC_W-2], 2))
    else $error("Second serial bit is not bit 510.");

  a_tx_ends: assert property (
    r.busy && r.cnt == cst_pkg::TX_LAST |=> !tx_valid)
    else $error("Serial copy did not end after 512 bits.");

  a_read_word0: assert property (
    rd_en && addr == cst_pkg::OFS_REC_FIRST |=> rdata == $past(rec[511:480]))
    else $error("Record word zero read back wrong.");

  a_read_unmapped: assert property (
    rd_en && addr > cst_pkg::OFS_TXSTAT |=> rdata == 32'h0)
    else $error("Unmapped read did not return zero.");

  a_width_one_taken: assert property (
    s_ctrl_wr |=> rec[511:510] == $past(wdata[1:0]) || $past(wdata[0]))
    else $error("One-line width not reported after select.");

  a_width_legal: assert property (
    rec[511:510] == cst_pkg::WIDTH_ONE || rec[511:510] == cst_pkg::WIDTH_FOUR)
    else $error("Width field holds a reserved code.");

  a_secure_hold: assert property (
    !(wr_en && addr == cst_pkg::OFS_CTRL) |=> $stable(rec[509]))
    else $error("Secure flag changed without a control write.");

  a_guarded_taken: assert property (
    s_guard_wr |=> rec[479:448] == $past(wdata))
    else $error("Guarded size not taken from the write.");

  a_guarded_hold: assert property (
    !(wr_en && addr == cst_pkg::OFS_GUARDED) |=> $stable(rec[479:448]))
    else $error("Guarded size changed without a write.");

  a_speed_taken: assert property (
    wr_en && addr == cst_pkg::OFS_PERF && wdata[7:0] <= cst_pkg::SPEED_MAX
    |=> rec[447:440] == $past(wdata[7:0]))
    else $error("Legal speed grade not taken.");

  a_speed_refused: assert property (
    wr_en && addr == cst_pkg::OFS_PERF && wdata[7:0] > cst_pkg::SPEED_MAX |=> $stable(r.speed))
    else $error("Reserved speed grade was taken.");

  a_move_taken: assert property (
    s_perf_wr |=> rec[439:432] == $past(wdata[15:8]))
    else $error("Move performance not taken from the write.");

  a_perf_hold: assert property (
    !(wr_en && addr == cst_pkg::OFS_PERF) |=> $stable(rec[447:428]))
    else $error("Performance fields changed without a write.");

  a_au_refused: assert property (
    wr_en && addr == cst_pkg::OFS_PERF && wdata[19:16] > cst_pkg::AU_MAX |=> $stable(r.au))
    else $error("Reserved allocation unit code was taken.");

  a_au_shown: assert property (
    r.au <= au_lim |-> rec[431:428] == r.au)
    else $error("Allowed allocation unit not shown as stored.");

  a_au_capped: assert property (
    r.au > au_lim |-> rec[431:428] == au_lim)
    else $error("Oversized allocation unit not capped.");

  a_esize_taken: assert property (
    s_erase_wr |=> rec[423:408] == $past(wdata[15:0]))
    else $error("Erase unit count not taken from the write.");

  a_etmo_taken: assert property (
    s_erase_wr |=> rec[407:402] == $past(wdata[21:16]))
    else $error("Erase time limit not taken from the write.");

  a_eoff_taken: assert property (
    s_erase_wr |=> rec[401:400] == $past(wdata[25:24]))
    else $error("Erase margin not taken from the write.");

  a_erase_hold: assert property (
    !(wr_en && addr == cst_pkg::OFS_ERASE) |=> $stable(rec[423:400]))
    else $error("Erase fields changed without a write.");

  a_record_readonly: assert property (
    wr_en && addr <= cst_pkg::OFS_REC_LAST |=> $stable(rec))
    else $error("A write to a record word changed the record.");

  a_tx_start_load: assert property (
    s_tx_begin |=> tx_valid && r.cnt == 9'h000)
    else $error("Serial copy did not start from bit count zero.");

  a_tx_shift_on: assert property (
    tx_valid && r.cnt != cst_pkg::TX_LAST |=> tx_valid && tx_bit == $past(r.shift[510]))
    else $error("Serial copy skipped or repeated a bit.");

  a_tx_busy_ignore: assert property (
    tx_valid && tx_start |=> r.cnt == $past(r.cnt) + 9'h001)
    else $error("Start request during a copy disturbed it.");

  a_tx_idle_low: assert property (
    !tx_valid |-> !tx_bit)
    else $error("Serial bit not low while idle.");

  a_read_idle_zero: assert property (
    !rd_en |=> rdata == 32'h0)
    else $error("Read data not zero outside a read answer.");

  a_read_txstat: assert property (
    rd_en && addr == cst_pkg::OFS_TXSTAT |=> rdata == {22'h0, $past(r.busy), $past(r.cnt)})
    else $error("Copy status read back wrong.");

  a_read_maker_zero: assert property (
    rd_en && addr == cst_pkg::OFS_REC_LAST |=> rdata == 32'h0)
    else $error("Maker area word not read as zero.");
endmodule

// ### bench/cst_host_model.sv
/*
  Host side of the serial record link: collects each valid bit of the record.
  Assumes the card drives tx_valid and tx_bit from registers on the same clock.
*/
`timescale 1ns/1ps
module cst_host_model (
  // Clock and capture control.
  input wire logic clk,
  input wire logic clr,
  // Serial record from the card.
  input wire logic tx_valid,
  input wire logic tx_bit,
  // Captured record and bit count.
  output logic [511:0] rec,
  output logic [9:0] nbits
);
  // Buffer size the host would reserve for one allocation unit.
  localparam int BUF_BYTES = 4194304;

  // Shift each bit in at the bottom so the first bit ends up on top.
  always @(posedge clk) begin
    if (clr) begin
      nbits <= 10'h000;
    end else if (tx_valid) begin
      rec <= {rec[510:0], tx_bit};
      nbits <= nbits + 10'h001;
    end
  end
endmodule

// ### bench/tb_card_status_record.sv
/*
  Self-checking bench of the card status record block.
  Assumes the block reads back its record words at byte offsets 4*i.
*/
`timescale 1ns/1ps
module tb_card_status_record;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clr = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic tx_start = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic tx_valid;
  logic tx_bit;
  logic [511:0] rec;
  logic [511:0] snap;
  logic [9:0] nbits;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  // Expected state of the card, starting at the reset values.
  logic [1:0] s_width = 2'h0;
  logic s_sec = 1'b0;
  logic [31:0] s_guard = 32'h02000000;
  logic [7:0] s_speed = 8'h02;
  logic [7:0] s_move = 8'h02;
  logic [3:0] s_au = 4'h9;
  logic [1:0] s_cap = 2'h3;
  logic [15:0] s_esize = 16'h0200;
  logic [5:0] s_etmo = 6'h2a;
  logic [1:0] s_eoff = 2'h2;

  // The clock inverts every half period of 10 ns.
  always #10 clk = ~clk;

  cst_status_record dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .tx_start(tx_start), .tx_valid(tx_valid), .tx_bit(tx_bit));
  cst_host_model host (.clk(clk), .clr(clr), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .rec(rec), .nbits(nbits));

  // ----------------------------------------------------------------
  // Reporting and comparison.
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rec(input logic [511:0] got, input logic [511:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The hang limit counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Bus cycles and expected record.
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  // The shown unit code is clamped to the limit of the capacity class.
  function automatic logic [511:0] exp_rec();
    logic [3:0] lim;
    lim = 4'h6 + {2'h0, s_cap};
    return {s_width, s_sec, 13'h0, 16'h0000, s_guard, s_speed, s_move,
      (s_au > lim) ? lim : s_au, 4'h0, s_esize, s_etmo, s_eoff, 88'h0, 312'h0};
  endfunction

  task automatic chk_rec();
    logic [511:0] e;
    logic [31:0] v;
    e = exp_rec();
    for (int i = 0; i < 16; i++) begin
      rd(8'(4 * i), v);
      cmp_word(v, e[511 - 32 * i -: 32]);
    end
  endtask

  // Reserved codes leave the field unchanged; other fields still load.
  task automatic wctrl(input logic [1:0] w, input logic sec);
    wr(8'h40, {29'h0, sec, w});
    if (w == 2'h0 || w == 2'h2) s_width = w;
    s_sec = sec;
    chk_rec();
  endtask

  task automatic wperf(input logic [7:0] sp, input logic [7:0] mv, input logic [3:0] au,
    input logic [1:0] cap);
    wr(8'h48, {10'h0, cap, au, mv, sp});
    if (sp <= 8'h03) s_speed = sp;
    s_move = mv;
    if (au <= 4'h9) s_au = au;
    s_cap = cap;
    chk_rec();
  endtask

  task automatic werase(input logic [15:0] cnt, input logic [5:0] tmo, input logic [1:0] off);
    wr(8'h4c, {6'h0, off, 2'h0, tmo, cnt});
    s_esize = cnt;
    s_etmo = tmo;
    s_eoff = off;
    chk_rec();
  endtask

  // A frame carries the record as it stood at the start, despite writes to the
  // control and guarded size registers and a second start request during the frame.
  task automatic frame();
    snap = exp_rec();
    @(posedge clk);
    clr <= 1'b0;
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    #1 cmp_word({31'h0, tx_valid}, 32'h1);
    rd(8'h50, d);
    cmp_word(d, 32'h201);
    wctrl(s_width ^ 2'h2, ~s_sec);
    wr(8'h44, ~s_guard);
    s_guard = ~s_guard;
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    for (int k = 0; k < 600 && tx_valid === 1'b1; k++) @(posedge clk);
    #1 cmp_word({22'h0, nbits}, 32'h200);
    cmp_rec(rec, snap);
    rd(8'h50, d);
    cmp_word(d, 32'h0);
    clr <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chk_rec();
    rd(8'h48, d);
    cmp_word(d, 32'h00390202);
    rd(8'h48, d);
    cmp_word(d, 32'h00390202);
    rd(8'h4c, d);
    cmp_word(32'(d[21:16]) * 32'h200 / 32'(d[15:0]) + 32'(d[25:24]), 32'h2c);
    rd(8'h50, d);
    cmp_word(d, 32'h0);
    @(posedge clk);
    #1 cmp_word(rdata, 32'h0);
    rd(8'h80, d);
    cmp_word(d, 32'h0);
    wctrl(2'h2, 1'b1);
    wctrl(2'h0, 1'b0);
    wctrl(2'h3, 1'b1);
    wctrl(2'h1, 1'b0);
    wr(8'h44, 32'h89abcdef);
    s_guard = 32'h89abcdef;
    wr(8'h00, 32'hffffffff);
    wr(8'h50, 32'hffffffff);
    chk_rec();
    for (int s = 0; s < 5; s++) wperf(8'(s), 8'(8'hfb + s), 4'h9, 2'h3);
    wperf(8'hff, 8'h00, 4'ha, 2'h3);
    for (int c = 0; c < 4; c++) wperf(8'h01, 8'h01, 4'h9, 2'(c));
    wperf(8'h03, 8'h01, 4'h1, 2'h0);
    werase(16'h0000, 6'h00, 2'h3);
    werase(16'hffff, 6'h3f, 2'h1);
    frame();
    frame();
    print_verdict();
  end
endmodule
